// File: embpc_chk_properties.sv
// Purpose: pin timing checks for the bus pin block
// Assumes: bound to embpc_ctrl
// Notes: a strobe is on when enabled and low
`timescale 1ns/10ps
`default_nettype none
module embpc_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic busy,
  input wire logic bus_drive_bit,
  input wire logic rd_valid_q,
  input wire logic port_b_per_we,
  input wire logic port_b_per_wdata,
  input wire logic port_b_peripheral_enable_q,
  input wire logic [15:0] port_f_peripheral_enable,
  input wire logic [15:0] data_oe,
  input wire logic read_strobe_n_o,
  input wire logic read_strobe_n_oe,
  input wire logic store_strobe_n_o,
  input wire logic store_strobe_n_oe,
  input wire logic [3:0] chip_select_lines_o,
  input wire logic [3:0] chip_select_lines_oe
);
  wire logic rd_on = read_strobe_n_oe & ~read_strobe_n_o;
  wire logic wr_on = store_strobe_n_oe & ~store_strobe_n_o;
  wire logic [15:0] bus_oe = data_oe & ~port_f_peripheral_enable;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_rd_fall;
    !rd_on ##1 rd_on;
  endsequence
  sequence s_rd_hold;
    rd_on [*4] ##1 !rd_on;
  endsequence
  a_read_len: assert property (s_rd_fall |-> s_rd_hold)
    else $error("read strobe length wrong");
  a_read_release: assert property (rd_on |-> bus_oe == 16'h0000)
    else $error("data driven during read");
  a_read_capture: assert property (rd_valid_q |-> $past(rd_on) && !rd_on)
    else $error("read data not at strobe rise");
  a_write_drive: assert property (wr_on |-> (data_oe | port_f_peripheral_enable) == 16'hFFFF)
    else $error("write data not driven");
  a_select_pair: assert property ((rd_on || wr_on) |-> chip_select_lines_oe[1:0] == 2'b11
    && chip_select_lines_o[1:0] != 2'b11 && chip_select_lines_o[1:0] != 2'b00)
    else $error("select wrong during strobe");
  a_idle_float: assert property (!bus_drive_bit && !busy |-> !read_strobe_n_oe
    && !store_strobe_n_oe && bus_oe == 16'h0000)
    else $error("idle bus not floated");
  a_reset_off: assert property (disable iff (1'b0) !arst_n |-> data_oe == 16'h0000
    && !read_strobe_n_oe && !store_strobe_n_oe && chip_select_lines_oe == 4'h0)
    else $error("output enabled in reset");
  a_per_write: assert property (port_b_per_we |=> port_b_peripheral_enable_q
    == $past(port_b_per_wdata))
    else $error("peripheral enable not written");
  a_strobe_excl: assert property (!(rd_on && wr_on))
    else $error("both strobes on");
endmodule
bind embpc_ctrl embpc_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .busy(busy),
  .bus_drive_bit(bus_drive_bit), .rd_valid_q(rd_valid_q), .port_b_per_we(port_b_per_we),
  .port_b_per_wdata(port_b_per_wdata),
  .port_b_peripheral_enable_q(port_b_peripheral_enable_q),
  .port_f_peripheral_enable(port_f_peripheral_enable), .data_oe(data_oe),
  .read_strobe_n_o(read_strobe_n_o), .read_strobe_n_oe(read_strobe_n_oe),
  .store_strobe_n_o(store_strobe_n_o), .store_strobe_n_oe(store_strobe_n_oe),
  .chip_select_lines_o(chip_select_lines_o), .chip_select_lines_oe(chip_select_lines_oe));
`default_nettype wire

// File: embpc_ctrl.v
// Purpose: external memory bus pin control with shared port functions
// Assumes: pins pass as input, output and output enable; pads resolve them
// Notes: configuration bits are plain ports, except the port b peripheral enable register
// Function
// - read strobe low throughout each external read cycle
// - data pins released to inputs while read strobe is low
// - read data captured when read strobe rises
// - store strobe low with write data driven onto data pins
// - address and selects valid only while a strobe is asserted
// - bus drive bit low floats address, data, controls when idle
// - chip select zero is program memory select, low on program access
// - chip select one is data memory select, low on data access
// - chip selects two, three region selects; port pins after reset
// - top address pin function at reset from boot, mode, security
// - port b peripheral enable writes override reset pin function
// - data pins default to bus; each may switch to port f
// - in reset data, strobe, select outputs off, pull-ups on
// - clearing pull-up bit n disables pull-up of port f or b pin n; port d bit n acts on chip select line n
// - control-pins bit in system pull-up disable turns strobe pull-ups off
// - each shared pin in port role is individually input or output
`timescale 1ns/10ps
`default_nettype none
`include "embpc_map.vh"
module embpc_ctrl (
  input wire clk_sys,
  input wire arst_n,
  input wire req_valid,
  output wire req_ready,
  input wire req_write,
  input wire req_program,
  input wire [16:0] req_addr,
  input wire [15:0] req_wdata,
  output reg rd_valid_q,
  output reg [15:0] rd_data_q,
  output wire busy,
  input wire bus_drive_bit,
  input wire cs2_region_hit,
  input wire cs3_region_hit,
  input wire boot_source_input,
  input wire memory_interface_mode_input,
  input wire flash_secure,
  input wire port_b_per_we,
  input wire port_b_per_wdata,
  output reg port_b_peripheral_enable_q,
  input wire [15:0] port_f_peripheral_enable,
  input wire [1:0] port_d_peripheral_enable,
  input wire [15:0] port_f_pullup_enable,
  input wire [3:0] port_d_pullup_enable,
  input wire port_b_pullup_enable,
  input wire system_pullup_disable_ctrl,
  input wire [15:0] port_f_dir,
  input wire [15:0] port_f_out,
  output wire [15:0] port_f_in,
  input wire [3:0] port_d_dir,
  input wire [3:0] port_d_out,
  output wire [3:0] port_d_in,
  input wire port_b_dir,
  input wire port_b_out,
  output wire port_b_in,
  output wire [15:0] addr_lo_o,
  output wire [15:0] addr_lo_oe,
  input wire port_b_pin_zero_i,
  output wire port_b_pin_zero_o,
  output wire port_b_pin_zero_oe,
  output wire port_b_pin_zero_pu,
  input wire [15:0] data_i,
  output wire [15:0] data_o,
  output wire [15:0] data_oe,
  output wire [15:0] data_pu,
  output wire read_strobe_n_o,
  output wire read_strobe_n_oe,
  output wire store_strobe_n_o,
  output wire store_strobe_n_oe,
  output wire strobe_pu,
  output wire [3:0] chip_select_lines_o,
  output wire [3:0] chip_select_lines_oe,
  output wire [3:0] chip_select_lines_pu,
  input wire [3:0] chip_select_lines_i
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RD = 3'b010;
  localparam ST_WR = 3'b100;
  localparam integer STB_CYC_I = `EMBPC_STROBE_CYC;
  localparam [1:0] STB_CYC = STB_CYC_I[1:0];

  function [3:0] sync_bits;
    input [3:0] s2;
    input [3:0] s3;
    input [3:0] prev;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        sync_bits[k] = (s2[k] == s3[k]) ? s3[k] : prev[k];
      end
    end
  endfunction

  // enable of a shared pin: bus role follows drive, port role its direction
  function pin_en;
    input bus;
    input drv_en;
    input dir;
    begin
      pin_en = bus ? drv_en : dir;
    end
  endfunction

  wire f_valid;
  wire f_ready;
  // request word: write, program, address, write data
  wire [34:0] f_data;
  embpc_fifo #(
    .WIDTH(`EMBPC_CMD_W),
    .DEPTH(`EMBPC_FIFO_DEPTH),
    .AW(`EMBPC_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_write, req_program, req_addr, req_wdata}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  reg [2:0] st_q;
  // strobe counter, loaded as a cycle starts; the cycle ends at zero
  reg [1:0] cnt_q;
  reg [16:0] addr_q;
  reg [15:0] wdat_q;
  reg prog_q;
  reg cs2_q;
  reg cs3_q;
  reg strap_done_q;
  // three-stage pin synchronisers; data pins read only through them
  reg [15:0] d_s1_q, d_s2_q, d_s3_q;
  reg [15:0] pf_s1_q, pf_s2_q, pf_s3_q, pf_q;
  reg [3:0] pd_s1_q, pd_s2_q, pd_s3_q, pd_q;
  reg [2:0] pb_s_q;
  reg pb_q;

  wire in_rd = st_q[1];
  wire in_wr = st_q[2];
  wire active = in_rd | in_wr;
  wire done = active & (cnt_q == 2'd0);
  assign f_ready = st_q[0];
  assign busy = ~st_q[0];

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 2'd0;
      addr_q <= 17'h00000;
      wdat_q <= 16'h0000;
      prog_q <= 1'b0;
      cs2_q <= 1'b0;
      cs3_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end else begin
      rd_valid_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (f_valid) begin
            addr_q <= f_data[32:16];
            wdat_q <= f_data[15:0];
            prog_q <= f_data[`EMBPC_BIT_PROG];
            cs2_q <= cs2_region_hit;
            cs3_q <= cs3_region_hit;
            cnt_q <= STB_CYC + 2'd1;
            // one state only, so strobes exclusive
            st_q <= f_data[`EMBPC_BIT_WR] ? ST_WR : ST_RD;
          end
        end
        ST_RD: begin
          if (done) begin
            // capture as strobe rises; pins sampled through synchroniser
            rd_data_q <= d_s3_q;
            rd_valid_q <= 1'b1;
            st_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 2'd1;
          end
        end
        ST_WR: begin
          if (done) begin
            st_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 2'd1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // reset pin function of the shared top address pin, overridable
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strap_done_q <= 1'b0;
      port_b_peripheral_enable_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      port_b_peripheral_enable_q <= boot_source_input & memory_interface_mode_input
                                    & ~flash_secure;
    end else if (port_b_per_we) begin
      port_b_peripheral_enable_q <= port_b_per_wdata;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      d_s1_q <= 16'h0000;
      d_s2_q <= 16'h0000;
      d_s3_q <= 16'h0000;
      pf_s1_q <= 16'h0000;
      pf_s2_q <= 16'h0000;
      pf_s3_q <= 16'h0000;
      pf_q <= 16'h0000;
      pd_s1_q <= 4'h0;
      pd_s2_q <= 4'h0;
      pd_s3_q <= 4'h0;
      pd_q <= 4'h0;
      pb_s_q <= 3'h0;
      pb_q <= 1'b0;
    end else begin
      d_s1_q <= data_i;
      d_s2_q <= d_s1_q;
      d_s3_q <= d_s2_q;
      pf_s1_q <= data_i;
      pf_s2_q <= pf_s1_q;
      pf_s3_q <= pf_s2_q;
      pf_q[3:0] <= sync_bits(pf_s2_q[3:0], pf_s3_q[3:0], pf_q[3:0]);
      pf_q[7:4] <= sync_bits(pf_s2_q[7:4], pf_s3_q[7:4], pf_q[7:4]);
      pf_q[11:8] <= sync_bits(pf_s2_q[11:8], pf_s3_q[11:8], pf_q[11:8]);
      pf_q[15:12] <= sync_bits(pf_s2_q[15:12], pf_s3_q[15:12], pf_q[15:12]);
      pd_s1_q <= {chip_select_lines_i[1:0], chip_select_lines_i[3:2]};
      pd_s2_q <= pd_s1_q;
      pd_s3_q <= pd_s2_q;
      pd_q <= sync_bits(pd_s2_q, pd_s3_q, pd_q);
      pb_s_q <= {pb_s_q[1:0], port_b_pin_zero_i};
      if (pb_s_q[1] == pb_s_q[2]) begin
        pb_q <= pb_s_q[2];
      end
    end
  end
  assign port_f_in = pf_q;
  assign port_d_in = pd_q;
  assign port_b_in = pb_q;

  // drive when active, or when idle with the drive bit set
  wire drv = active | bus_drive_bit;
  // reset forces enables low through the flops' reset values
  wire run = strap_done_q;
  wire pu_force = ~run;

  assign read_strobe_n_o = ~in_rd;
  assign store_strobe_n_o = ~in_wr;
  assign read_strobe_n_oe = run & drv;
  assign store_strobe_n_oe = run & drv;
  assign strobe_pu = ~system_pullup_disable_ctrl | pu_force;

  // address and selects qualified by strobes; held stable while active
  assign addr_lo_o = addr_q[15:0];
  assign addr_lo_oe = {16{run & drv}};
  wire pb_bus = port_b_peripheral_enable_q;
  assign port_b_pin_zero_o = pb_bus ? addr_q[16] : port_b_out;
  assign port_b_pin_zero_oe = run & pin_en(pb_bus, drv, port_b_dir);
  assign port_b_pin_zero_pu = port_b_pullup_enable | pu_force;

  // data pins: bus role unless switched to port f
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_dat
      wire bus_role = ~port_f_peripheral_enable[g];
      assign data_o[g] = bus_role ? wdat_q[g] : port_f_out[g];
      // released during reads, driven during writes or idle drive
      assign data_oe[g] = run & pin_en(bus_role, ~in_rd & (in_wr | bus_drive_bit),
                                       port_f_dir[g]);
      assign data_pu[g] = port_f_pullup_enable[g] | pu_force;
    end
  endgenerate

  // select zero is program, one is data memory select
  wire [3:0] cs_n;
  assign cs_n[0] = ~(active & prog_q);
  assign cs_n[1] = ~(active & ~prog_q);
  assign cs_n[2] = ~(active & cs2_q);
  assign cs_n[3] = ~(active & cs3_q);
  // two and three are port d pins unless enabled for the bus
  assign chip_select_lines_o[1:0] = cs_n[1:0];
  assign chip_select_lines_oe[1:0] = {2{run & drv}};
  assign chip_select_lines_o[2] = port_d_peripheral_enable[0] ? cs_n[2] : port_d_out[0];
  assign chip_select_lines_o[3] = port_d_peripheral_enable[1] ? cs_n[3] : port_d_out[1];
  assign chip_select_lines_oe[2] = run & pin_en(port_d_peripheral_enable[0], drv, port_d_dir[0]);
  assign chip_select_lines_oe[3] = run & pin_en(port_d_peripheral_enable[1], drv, port_d_dir[1]);
  assign chip_select_lines_pu = port_d_pullup_enable | {4{pu_force}};
  wire unused_ok = &{port_d_dir[3:2], port_d_out[3:2], 1'b0};
endmodule
`default_nettype wire

// File: embpc_fifo.v
// Purpose: request fifo for the external memory bus
// Assumes: single clock
// Notes: read data come out of a register
`timescale 1ns/10ps
`default_nettype none
module embpc_fifo #(
  parameter WIDTH = 34,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys,
  input wire arst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  reg ov_q;
  wire [AW:0] cnt = wp_q - rp_q;
  wire full = (cnt == DEPTH[AW:0]);
  wire empty = (wp_q == rp_q);
  wire pop = (~ov_q | out_ready) & ~empty;
  assign in_ready = ~full;
  assign out_valid = ov_q;
  always @(posedge clk_sys) begin
    if (in_valid & ~full) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
      ov_q <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (in_valid & ~full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rp_q[AW-1:0]];
        rp_q <= rp_q + 1'b1;
        ov_q <= 1'b1;
      end else if (out_ready) begin
        ov_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: embpc_map.vh
// Purpose: constants for the external memory bus pin control block
// Assumes: included by bare name
// Notes: widths are fixed
`ifndef EMBPC_MAP_VH
`define EMBPC_MAP_VH
`define EMBPC_DATA_W 16
`define EMBPC_ADDR_W 17
`define EMBPC_FIFO_DEPTH 16
`define EMBPC_FIFO_AW 4
`define EMBPC_CMD_W 35
`define EMBPC_STROBE_NS 200
`define EMBPC_CLK_NS 100
`define EMBPC_STROBE_CYC ((`EMBPC_STROBE_NS + `EMBPC_CLK_NS - 1) / `EMBPC_CLK_NS)
`define EMBPC_PF_RST 16'hFFFF
`define EMBPC_PD_RST 4'hF
`define EMBPC_PB_RST 1'h1
`define EMBPC_SPUD_RST 1'h0
`define EMBPC_DRV_RST 1'h0
`define EMBPC_BIT_WR 34
`define EMBPC_BIT_PROG 33
`endif

// File: embpc_sram_model.sv
// Purpose: far-side static memory for the bus pin bench
// Assumes: pin levels already resolved by the bench
// Notes: 256 words on the low address bits
`timescale 1ns/10ps
`default_nettype none
module embpc_sram_model (
  input wire logic clk_sys,
  input wire logic [15:0] addr,
  input wire logic [15:0] data_bus,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic sel_n,
  output logic [15:0] drv_data,
  output logic drv_oe
);
  logic [15:0] mem [0:255];
  logic [15:0] wd = 16'h0000;
  logic [7:0] wa = 8'h00;
  logic wv = 1'b0;
  // drive only while selected and read strobe low; else inverse of last
  assign drv_oe = !rd_n && !sel_n;
  assign drv_data = drv_oe ? mem[addr[7:0]] : ~wd;
  // take address and data only while qualified, store when strobe rises
  always @(posedge clk_sys) begin
    if (!wr_n && !sel_n) begin
      wa <= addr[7:0];
      wd <= data_bus;
      wv <= 1'b1;
    end else if (wv) begin
      mem[wa] <= wd;
      wv <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: embpc_tb.sv
// Purpose: self-checking bench for the bus pin block
// Assumes: 10 MHz clock, memory model on the far side
// Notes: pin levels resolved from enables and pull-ups
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys, arst_n, req_valid, req_ready, req_write, req_program, rd_valid_q, busy, m_oe;
  logic bus_drive_bit, cs2_region_hit, cs3_region_hit, boot_source_input, flash_secure;
  logic memory_interface_mode_input, port_b_per_we, port_b_per_wdata, port_b_peripheral_enable_q;
  logic port_b_pullup_enable, system_pullup_disable_ctrl, port_b_dir, port_b_out, port_b_in;
  logic port_b_pin_zero_i, port_b_pin_zero_o, port_b_pin_zero_oe, port_b_pin_zero_pu, strobe_pu;
  logic read_strobe_n_o, read_strobe_n_oe, store_strobe_n_o, store_strobe_n_oe;
  logic [16:0] req_addr;
  logic [15:0] req_wdata, rd_data_q, port_f_peripheral_enable, port_f_pullup_enable, port_f_dir;
  logic [15:0] port_f_out, port_f_in, addr_lo_o, addr_lo_oe, data_i, data_o, data_oe, data_pu, m_d;
  logic [3:0] port_d_pullup_enable, port_d_dir, port_d_out, port_d_in, chip_select_lines_o;
  logic [3:0] chip_select_lines_oe, chip_select_lines_pu, chip_select_lines_i;
  logic [1:0] port_d_peripheral_enable;
  int fails, cmp_count;
  embpc_ctrl dut (.*);
  embpc_sram_model u_mem (.clk_sys(clk_sys), .addr(addr_lo_o), .data_bus(data_i),
    .rd_n(read_strobe_n_oe ? read_strobe_n_o : strobe_pu),
    .wr_n(store_strobe_n_oe ? store_strobe_n_o : strobe_pu),
    .sel_n(&chip_select_lines_i[1:0]), .drv_data(m_d), .drv_oe(m_oe));
  assign data_i = (data_oe & data_o) | (~data_oe & (m_oe ? m_d : data_pu));
  assign chip_select_lines_i = (chip_select_lines_oe & chip_select_lines_o)
    | (~chip_select_lines_oe & chip_select_lines_pu);
  assign port_b_pin_zero_i = port_b_pin_zero_oe ? port_b_pin_zero_o : port_b_pin_zero_pu;
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic finish_test;
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic w, input logic p, input logic [16:0] a,
    input logic [15:0] d, output logic r);
    int n;
    r = 1'b0;
    req_valid <= 1'b1;
    req_write <= w;
    req_program <= p;
    req_addr <= a;
    req_wdata <= d;
    for (n = 0; n < 300; n++) begin
      @(negedge clk_sys);
      if (req_ready === 1'b1) break;
      r = 1'b1;
    end
    @(posedge clk_sys);
    if (n == 300) begin
      fails++;
      finish_test;
    end
  endtask
  task automatic rd(input logic p, input logic [16:0] a, input logic [15:0] e);
    logic r;
    logic [1:0] cs;
    int n;
    req(1'b0, p, a, 16'h0000, r);
    req_valid <= 1'b0;
    for (n = 0; n < 300; n++) begin
      @(negedge clk_sys);
      if (!read_strobe_n_o && read_strobe_n_oe) cs = chip_select_lines_o[1:0];
      if (rd_valid_q === 1'b1) break;
    end
    @(posedge clk_sys);
    if (n == 300) begin
      fails++;
      finish_test;
    end
    chk(rd_data_q, e);
    chk(cs, p ? 2'b10 : 2'b01);
  endtask
  task automatic t_reset;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({data_oe, read_strobe_n_oe}, 17'h00000);
    chk(data_pu, 16'hFFFF);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(port_b_peripheral_enable_q, 1'b1);
    @(posedge clk_sys);
    port_b_per_we <= 1'b1;
    port_b_dir <= 1'b1;
    port_b_out <= 1'b1;
    @(posedge clk_sys);
    port_b_per_wdata <= 1'b1;
    @(negedge clk_sys);
    chk(port_b_peripheral_enable_q, 1'b0);
    chk({port_b_pin_zero_oe, port_b_pin_zero_o}, 2'b11);
    @(posedge clk_sys);
    port_b_per_we <= 1'b0;
  endtask
  task automatic t_pins;
    port_f_peripheral_enable <= 16'h0001;
    port_f_dir <= 16'h0001;
    port_f_out <= 16'h0001;
    port_f_pullup_enable <= 16'hFDFF;
    system_pullup_disable_ctrl <= 1'b1;
    port_d_dir <= 4'h1;
    bus_drive_bit <= 1'b0;
    @(negedge clk_sys);
    chk({data_oe[1:0], data_o[0]}, 3'b011);
    chk({data_pu[9], strobe_pu}, 2'b00);
    chk({chip_select_lines_oe, read_strobe_n_oe}, 5'h08);
    @(posedge clk_sys);
    bus_drive_bit <= 1'b1;
    port_f_peripheral_enable <= 16'h0000;
    port_f_pullup_enable <= 16'hFFFF;
    system_pullup_disable_ctrl <= 1'b0;
    @(negedge clk_sys);
    chk({read_strobe_n_oe, read_strobe_n_o, chip_select_lines_o[1:0]}, 4'hF);
    chk(addr_lo_oe, 16'hFFFF);
    chk({busy, store_strobe_n_oe, store_strobe_n_o}, 3'h3);
    chk({port_b_pin_zero_oe, port_b_pin_zero_o, port_b_pin_zero_pu}, 3'h5);
    chk(chip_select_lines_pu, 4'hF);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({port_d_in, port_b_in}, 5'h1C);
    @(posedge clk_sys);
  endtask
  task automatic t_full;
    logic r;
    logic hit;
    hit = 1'b0;
    req(1'b1, 1'b1, 17'h00005, 16'hA5A5, r);
    req(1'b1, 1'b0, 17'h00009, 16'h3C3C, r);
    rd(1'b1, 17'h00005, 16'hA5A5);
    rd(1'b0, 17'h00009, 16'h3C3C);
    for (int i = 0; i < 26; i++) begin
      req(1'b1, 1'b0, 17'(i + 16), 16'h1000 + 16'(i), r);
      hit |= r;
    end
    chk(hit, 1'b1);
    rd(1'b0, 17'h00029, 16'h1019);
  endtask
  initial begin
    fails = 0;
    cmp_count = 0;
    arst_n = 1'b1;
    {req_valid, req_write, req_program, req_addr, req_wdata, cs2_region_hit,
      cs3_region_hit, flash_secure, port_b_per_we, port_b_per_wdata, port_b_dir, port_b_out,
      system_pullup_disable_ctrl, port_f_peripheral_enable, port_f_dir, port_f_out,
      port_d_peripheral_enable, port_d_dir, port_d_out} = '0;
    {port_f_pullup_enable, port_d_pullup_enable, port_b_pullup_enable, boot_source_input,
      memory_interface_mode_input} = '1;
    bus_drive_bit = 1'b1;
    #10;
    arst_n = 1'b0;
    t_reset;
    t_pins;
    t_full;
    finish_test;
  end
endmodule
`default_nettype wire
